/* File: core/external_bus_mode_timing.sv */
`timescale 1ns/100ps
// access sequencer for one external memory bus with eight chip-select areas
module external_bus_mode_timing
  import ext_bus_timing_pkg::*;
(
  input  wire logic                 clk_in,
  input  wire logic                 arst_n_in,
  // register port
  input  wire logic                 reg_wr_in,
  input  wire logic                 reg_sel_tim_in,
  input  wire logic [area_bits-1:0] reg_area_in,
  input  wire logic [31:0]          reg_wdata_in,
  output logic      [31:0]          reg_rdata_out,
  // access request from the internal master
  input  wire logic                 req_valid_in,
  input  wire logic                 req_write_in,
  input  wire logic [area_bits-1:0] req_area_in,
  input  wire logic [24:0]          req_addr_in,
  input  wire logic [15:0]          req_wdata_in,
  input  wire logic [1:0]           req_lanes_in,
  input  wire logic                 req_burst_in,
  output logic                      req_ready_out,
  output logic                      rd_valid_out,
  output logic      [15:0]          rd_data_out,
  // memory pins
  output logic      [num_areas-1:0] chip_select_n,
  output logic                      output_enable_n,
  output logic                      write_enable_n,
  output logic      [1:0]           byte_mask_out,
  output logic                      nand_read_strobe_n,
  output logic                      nand_write_strobe_n,
  output logic      [24:0]          addr_out,
  output logic      [15:0]          data_out,
  output logic                      data_oe_out,
  input  wire logic [15:0]          data_in,
  input  wire logic                 external_wait_in,
  input  wire logic [3:0]           addr_latch_count_in
);
  logic [31:0]          mode_w [num_areas];
  logic [31:0]          tim_w  [num_areas];
  bus_state_t           state;
  logic [area_bits-1:0] cur_area;
  logic                 cur_write;
  logic                 cur_burst;
  logic [1:0]           cur_lanes;
  logic [4:0]           cnt;
  logic                 first_beat;
  logic                 wait_q1;
  logic                 wait_q2;
  logic                 apply;

  // every area's words are frozen during an access; a write stays pending until its apply
  assign apply = (state == st_idle);

  genvar g;
  generate
    for (g = 0; g < num_areas; g++) begin : g_area
      area_reg_bank #(
        .mode_init ((g == int'(wide_area)) ? mode_reset_w16 : mode_reset)
      ) u_bank (
        .clk_in     (clk_in),
        .arst_n_in  (arst_n_in),
        .mode_we_in (reg_wr_in && !reg_sel_tim_in && reg_area_in == area_bits'(g)),
        .tim_we_in  (reg_wr_in && reg_sel_tim_in && reg_area_in == area_bits'(g)),
        .wdata_in   (reg_wdata_in),
        .apply_in   (apply),
        .mode_out   (mode_w[g]),
        .tim_out    (tim_w[g])
      );
    end
  endgenerate

  assign reg_rdata_out = reg_sel_tim_in ? tim_w[reg_area_in] : mode_w[reg_area_in];

  // decoded fields of the active area
  logic [31:0] md;
  logic [31:0] tm;
  logic [3:0]  read_access_count, read_setup_count, first_read_count, read_idle_count, write_access_count, write_setup_count, write_strobe_count, write_idle_count;
  logic        page_on, nand_on, we_off, rd_mask, rdy_on, short_hold, mux_on, no_addr, cs_off, oe_sel;
  logic        wide;
  assign md         = mode_w[cur_area];
  assign tm         = tim_w[cur_area];
  assign read_access_count       = tm[read_access_count_lsb +: 4];
  assign read_setup_count       = tm[read_setup_count_lsb +: 4];
  assign first_read_count      = tm[first_read_count_lsb +: 4];
  assign read_idle_count      = tm[read_idle_count_lsb +: 4];
  assign write_access_count       = tm[write_access_count_lsb +: 4];
  assign write_setup_count       = tm[write_setup_count_lsb +: 4];
  assign write_strobe_count       = tm[write_strobe_count_lsb +: 4];
  assign write_idle_count      = tm[write_idle_count_lsb +: 4];
  assign page_on    = md[page_bit];
  assign nand_on    = md[nand_bit];
  assign we_off     = md[we_dis_bit];
  assign rd_mask    = md[rd_mask_bit];
  assign rdy_on     = md[ready_bit];
  assign short_hold = md[short_hold_bit];
  assign mux_on     = md[mux_bit];
  assign no_addr    = md[no_addr_bit];
  assign cs_off     = md[cs_off_bit];
  assign oe_sel     = md[oe_sel_bit];
  assign wide       = (md[width_lsb +: 2] == width_16);

  // wait pin is sampled twice; only the second stage steers the strobes
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wait_q1 <= 1'b1;
      wait_q2 <= 1'b1;
    end else begin
      wait_q1 <= external_wait_in;
      wait_q2 <= wait_q1;
    end
  end

  // ready is ignored in page and nand modes, where stretching is not defined
  logic stretch;
  assign stretch = rdy_on && !page_on && !nand_on && !wait_q2;

  // read window: setup, oe phase end, access end (all counts from zero)
  logic [4:0] rd_last;
  logic [4:0] oe_start;
  logic [4:0] oe_end;
  logic       oe_win;
  always_comb begin
    if (page_on && !first_beat) begin
      rd_last  = {1'b0, read_access_count};
      oe_start = 5'h00;
    end else if (page_on) begin
      // a first-read value of zero means no extra wait before the page access
      rd_last  = 5'({1'b0, first_read_count} + {1'b0, read_access_count});
      oe_start = 5'h00;
    end else begin
      rd_last  = {1'b0, read_access_count};
      oe_start = {1'b0, read_setup_count};
    end
    if (!page_on && oe_sel) begin
      oe_end = 5'({1'b0, read_setup_count} + {1'b0, first_read_count});
    end else begin
      oe_end = rd_last;
    end
  end
  assign oe_win = (state == st_read) && (cnt >= oe_start) && (cnt <= oe_end);

  // write window: setup then strobe
  logic we_win;
  assign we_win = (state == st_write) && (cnt > {1'b0, write_setup_count}) &&
                  (cnt <= 5'({1'b0, write_setup_count} + {1'b0, write_strobe_count} + one5));

  // page continues while the next address stays inside the 16-byte block
  logic page_more;
  assign page_more = req_valid_in && !req_write_in && req_area_in == cur_area &&
                     req_addr_in[24:4] == addr_out[24:4] && req_addr_in[3:0] != zero4;

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state      <= st_idle;
      cnt        <= 5'h00;
      cur_area   <= '0;
      cur_write  <= 1'b0;
      cur_burst  <= 1'b0;
      cur_lanes  <= mask_none;
      first_beat <= 1'b0;
      addr_out   <= '0;
      data_out   <= '0;
    end else begin
      case (state)
        st_idle: begin
          if (req_valid_in) begin
            cur_area   <= req_area_in;
            cur_write  <= req_write_in;
            cur_burst  <= req_burst_in;
            cur_lanes  <= req_lanes_in;
            addr_out   <= req_addr_in;
            data_out   <= req_wdata_in;
            first_beat <= 1'b1;
            cnt        <= 5'h00;
            state      <= mode_w[req_area_in][mux_bit] ? st_latch :
                          (req_write_in ? st_write : st_read);
          end
        end
        st_latch: begin
          if (cnt[3:0] == addr_latch_count_in) begin
            cnt   <= 5'h00;
            state <= cur_write ? st_write : st_read;
          end else begin
            cnt <= cnt + one5;
          end
        end
        st_read: begin
          if (oe_win && stretch) begin
            cnt <= cnt;
          end else if (cnt == rd_last) begin
            cnt        <= 5'h00;
            first_beat <= 1'b0;
            if (page_on && page_more) begin
              addr_out <= req_addr_in;
            end else begin
              state <= st_rest;
            end
          end else begin
            cnt <= cnt + one5;
          end
        end
        st_write: begin
          if (we_win && stretch) begin
            cnt <= cnt;
          end else if (cnt == {1'b0, write_access_count}) begin
            cnt   <= 5'h00;
            state <= st_rest;
          end else begin
            cnt <= cnt + one5;
          end
        end
        st_rest: begin
          if (cnt == {1'b0, (cur_write ? write_idle_count : read_idle_count)}) begin
            cnt   <= 5'h00;
            state <= st_idle;
          end else begin
            cnt <= cnt + one5;
          end
        end
        default: state <= st_idle;
      endcase
    end
  end

  // read data captured in the last access cycle
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rd_data_out  <= '0;
      rd_valid_out <= 1'b0;
    end else begin
      rd_valid_out <= (state == st_read) && (cnt == rd_last) && !(oe_win && stretch);
      if ((state == st_read) && (cnt == rd_last)) begin
        rd_data_out <= data_in;
      end
    end
  end

  assign req_ready_out = (state == st_idle) ||
                         ((state == st_read) && page_on && (cnt == rd_last) && page_more);

  // chip selects: nand areas are pinned low, all others high when idle
  always_comb begin
    for (int i = 0; i < num_areas; i++) begin
      chip_select_n[i] = !mode_w[i][nand_bit];
    end
    if (state != st_idle && state != st_rest && !nand_on &&
        !(state == st_latch && mux_on && cs_off)) begin
      chip_select_n[cur_area] = 1'b0;
    end
  end

  // nand areas use the dedicated strobes with the same timing fields
  assign output_enable_n     = !(oe_win && !nand_on);
  assign nand_read_strobe_n  = !(oe_win && nand_on);
  assign write_enable_n      = !(we_win && !nand_on && !we_off);
  assign nand_write_strobe_n = !(we_win && nand_on);

  // byte masks low on enabled lanes; read masking only when enabled
  logic [1:0] lane_sel;
  assign lane_sel = wide ? cur_lanes : mask_all;
  always_comb begin
    if (we_win) begin
      byte_mask_out = ~lane_sel;
    end else if (oe_win && rd_mask) begin
      byte_mask_out = ~lane_sel;
    end else begin
      byte_mask_out = mask_none;
    end
  end

  // data drive: address phase, write phase, then idle hold choice
  logic last_idle;
  assign last_idle = (cnt == {1'b0, write_idle_count});
  always_comb begin
    data_oe_out = 1'b0;
    if (state == st_latch) begin
      data_oe_out = !no_addr;
    end else if (state == st_write) begin
      data_oe_out = 1'b1;
    end else if (state == st_rest && cur_write) begin
      data_oe_out = short_hold ? 1'b0 : !last_idle;
    end
  end

  // ---------------- assertions ----------------
  property p_cs_nand_low;
    @(posedge clk_in) disable iff (!arst_n_in) nand_on |-> !chip_select_n[cur_area];
  endproperty
  a_cs_nand_low: assert property (p_cs_nand_low) else $error("nand area chip select not held low");
  property p_we_off;
    @(posedge clk_in) disable iff (!arst_n_in) we_off |-> write_enable_n;
  endproperty
  a_we_off: assert property (p_we_off) else $error("write strobe active while disabled");
  property p_rd_nomask;
    @(posedge clk_in) disable iff (!arst_n_in) (state == st_read && !rd_mask) |-> byte_mask_out == mask_none;
  endproperty
  a_rd_nomask: assert property (p_rd_nomask) else $error("read mask driven while disabled");
  property p_setup_no_oe;
    @(posedge clk_in) disable iff (!arst_n_in)
      (state == st_read && !page_on && cnt < {1'b0, read_setup_count}) |-> output_enable_n;
  endproperty
  a_setup_no_oe: assert property (p_setup_no_oe) else $error("oe during read setup");
  property p_rd_capture;
    @(posedge clk_in) disable iff (!arst_n_in)
      (state == st_read && !page_on && cnt == {1'b0, read_access_count} && !stretch) |=> rd_valid_out;
  endproperty
  a_rd_capture: assert property (p_rd_capture) else $error("read data not captured");
  property p_wr_addr_stable;
    @(posedge clk_in) disable iff (!arst_n_in)
      (state == st_write && $past(state) == st_write) |-> $stable(addr_out);
  endproperty
  a_wr_addr_stable: assert property (p_wr_addr_stable) else $error("write address moved");
  property p_we_after_setup;
    @(posedge clk_in) disable iff (!arst_n_in)
      (state == st_write && cnt <= {1'b0, write_setup_count}) |-> write_enable_n && nand_write_strobe_n;
  endproperty
  a_we_after_setup: assert property (p_we_after_setup) else $error("write strobe in setup");
  property p_cs_off_latch;
    @(posedge clk_in) disable iff (!arst_n_in)
      (state == st_latch && cs_off) |-> chip_select_n[cur_area];
  endproperty
  a_cs_off_latch: assert property (p_cs_off_latch) else $error("cs asserted in latch period");
  property p_rest_len;
    @(posedge clk_in) disable iff (!arst_n_in)
      ($rose(state == st_rest) && cnt == 5'h00 && read_idle_count == zero4 && !cur_write) |=> state == st_idle;
  endproperty
  a_rest_len: assert property (p_rest_len) else $error("read idle length wrong");
  c_write: cover property (@(posedge clk_in) disable iff (!arst_n_in) state == st_write ##1 state == st_rest);
  c_read: cover property (@(posedge clk_in) disable iff (!arst_n_in) rd_valid_out);
  c_latch: cover property (@(posedge clk_in) disable iff (!arst_n_in) state == st_latch ##1 state == st_write);
  c_page: cover property (@(posedge clk_in) disable iff (!arst_n_in) page_on && rd_valid_out ##[1:20] rd_valid_out);
endmodule

/* File: inc/ext_bus_timing_pkg.sv */
// Notes on behaviour
// - external wait stretches strobes only while ready mode bit is set; reset off
// - page read: first read uses first-read count, then read count to 16-byte boundary
// - nand mode holds chip select low and uses nand strobes; otherwise cs high
// - write strobe disable bit holds write enable high for every access
// - read lane mask bit drives byte masks on reads for unneeded lanes
// - width field: 00 8-bit, 01 16-bit; area 4 resets to 01, others 00
// - oe width: access minus setup plus one, or first-read count plus one; page mode asserts with cs
// - multiplex with cs-off bit keeps chip select deasserted during address latch
// - long write data hold keeps write data through idle, releases in last cycle
// - write idle bits 31:28 insert value plus one idle cycles; reset 0000
// - write enable and byte mask asserted value plus one cycles; reset 0101
// - write address set up value plus one cycles before write enable; reset 0101
// - write access lasts value plus one cycles, address constant; reset 1111
// - read idle inserts value plus one idle cycles after each read; reset 1111
// - first-read count sets oe width plus one, or initial page wait 0 to 15
// - read setup cycles assert cs and address with oe held inactive
// - read access lasts value plus one cycles; data captured in the last one
// - nand strobes take their timing from the write enable and oe fields
// - mode bits: page 5, nand 4, we disable 3, read mask 2, width 1:0
// - register writes during an access take effect after the access completes
// - multiplex address latch drives address on data lines for latch count plus one; code drives data_out (request write data) there instead
package ext_bus_timing_pkg;
  localparam int unsigned num_areas      = 8;
  localparam int unsigned area_bits      = 3;
  localparam logic [2:0]  wide_area      = 3'h4;
  localparam int unsigned page_bytes     = 16;
  // mode register fields
  localparam int unsigned width_lsb      = 0;
  localparam int unsigned rd_mask_bit    = 2;
  localparam int unsigned we_dis_bit     = 3;
  localparam int unsigned nand_bit       = 4;
  localparam int unsigned page_bit       = 5;
  localparam int unsigned ready_bit      = 6;
  localparam int unsigned short_hold_bit = 7;
  localparam int unsigned mux_bit        = 8;
  localparam int unsigned no_addr_bit    = 11;
  localparam int unsigned cs_off_bit     = 12;
  localparam int unsigned oe_sel_bit     = 13;
  localparam logic [31:0] mode_rw_mask   = 32'h0000_3bff;
  localparam logic [31:0] mode_reset     = 32'h0000_0000;
  localparam logic [31:0] mode_reset_w16 = 32'h0000_0001;
  // timing register fields
  localparam int unsigned read_access_count_lsb       = 0;
  localparam int unsigned read_setup_count_lsb       = 4;
  localparam int unsigned first_read_count_lsb      = 8;
  localparam int unsigned read_idle_count_lsb      = 12;
  localparam int unsigned write_access_count_lsb       = 16;
  localparam int unsigned write_setup_count_lsb       = 20;
  localparam int unsigned write_strobe_count_lsb       = 24;
  localparam int unsigned write_idle_count_lsb      = 28;
  localparam logic [31:0] tim_reset      = 32'h055f_f00f;
  localparam logic [3:0]  one4           = 4'h1;
  localparam logic [3:0]  zero4          = 4'h0;
  localparam logic [4:0]  one5           = 5'h01;
  localparam logic [1:0]  width_16       = 2'h1;
  localparam logic [1:0]  mask_none      = 2'h0;
  localparam logic [1:0]  mask_all       = 2'h3;

  typedef enum logic [2:0] {
    st_idle,
    st_latch,
    st_read,
    st_write,
    st_rest
  } bus_state_t;
endpackage

/* File: core/area_reg_bank.sv */
`timescale 1ns/100ps
// one area's mode and timing words; writes are held as pending until the
// controller says no access is running, so reads return the old value
module area_reg_bank
  import ext_bus_timing_pkg::*;
#(
  parameter logic [31:0] mode_init = mode_reset
) (
  input  wire logic        clk_in,
  input  wire logic        arst_n_in,
  input  wire logic        mode_we_in,
  input  wire logic        tim_we_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic        apply_in,
  output logic      [31:0] mode_out,
  output logic      [31:0] tim_out
);
  logic [31:0] mode_pend;
  logic [31:0] tim_pend;
  logic        mode_dirty;
  logic        tim_dirty;

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      mode_pend  <= mode_init;
      mode_dirty <= 1'b0;
      mode_out   <= mode_init;
    end else begin
      if (mode_we_in) begin
        mode_pend  <= wdata_in & mode_rw_mask;
        mode_dirty <= 1'b1;
      end else if (apply_in && mode_dirty) begin
        mode_out   <= mode_pend;
        mode_dirty <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tim_pend  <= tim_reset;
      tim_dirty <= 1'b0;
      tim_out   <= tim_reset;
    end else begin
      if (tim_we_in) begin
        tim_pend  <= wdata_in;
        tim_dirty <= 1'b1;
      end else if (apply_in && tim_dirty) begin
        tim_out   <= tim_pend;
        tim_dirty <= 1'b0;
      end
    end
  end
endmodule

/* File: tb/mem_model.sv */
`timescale 1ns/100ps
// far-side memory; when nobody reads, the bus shows the inverse of its last value
module mem_model (
  input  wire logic        clk_in,
  input  wire logic [7:0]  cs_n_in,
  input  wire logic        oe_n_in,
  input  wire logic        we_n_in,
  input  wire logic [1:0]  mask_in,
  input  wire logic        nre_n_in,
  input  wire logic [24:0] addr_in,
  input  wire logic [15:0] wdata_in,
  input  wire logic        wdata_oe_in,
  output logic      [15:0] rdata_out
);
  logic [15:0] mem [256];
  logic [15:0] last = 16'h0;
  wire         sel  = ~&cs_n_in;
  wire         rd   = (sel & ~oe_n_in) | ~nre_n_in;
  // a masked lane is not written
  always @(posedge clk_in) begin
    last <= rdata_out;
    if (sel && !we_n_in && wdata_oe_in) begin
      if (!mask_in[0]) mem[addr_in[7:0]][7:0] <= wdata_in[7:0];
      if (!mask_in[1]) mem[addr_in[7:0]][15:8] <= wdata_in[15:8];
    end
  end
  assign rdata_out = rd ? mem[addr_in[7:0]] : ~last;
endmodule

/* File: tb/tb.sv */
`timescale 1ns/100ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin bad_count++; $display("BAD %s exp %0h got %0h", n, e, g); end end
module tb;
  import ext_bus_timing_pkg::*;
  localparam int k_cs = 0, k_oe = 1, k_we = 2, k_nre = 3, k_nwe = 4, k_pre = 5, k_set = 6, k_idl = 7, k_dho = 8;
  logic        clk_in, arst_n_in, reg_wr_in, reg_sel_tim_in, req_valid_in, req_write_in, req_ready_out;
  logic        rd_valid_out, output_enable_n, write_enable_n, nand_read_strobe_n, nand_write_strobe_n;
  logic        data_oe_out, external_wait_in, mon, seen, wseen;
  logic [2:0]  reg_area_in, req_area_in, ca;
  logic [31:0] reg_wdata_in, reg_rdata_out, tw;
  logic [24:0] req_addr_in, addr_out;
  logic [15:0] req_wdata_in, rd_data_out, data_out, data_in, rd;
  logic [1:0]  req_lanes_in, byte_mask_out, mk;
  logic [7:0]  chip_select_n;
  logic [3:0]  addr_latch_count_in, read_access_count, read_setup_count, first_read_count, read_idle_count, write_access_count, write_setup_count, write_strobe_count, write_idle_count;
  int          bad_count, comparisons, cyc;
  int          cnt [9];
  int          exp_mem [int];

  external_bus_mode_timing external_bus_mode_timing_inst (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .reg_wr_in(reg_wr_in), .reg_sel_tim_in(reg_sel_tim_in),
    .reg_area_in(reg_area_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
    .req_valid_in(req_valid_in), .req_write_in(req_write_in), .req_area_in(req_area_in),
    .req_addr_in(req_addr_in), .req_wdata_in(req_wdata_in), .req_lanes_in(req_lanes_in),
    .req_burst_in(1'b0), .req_ready_out(req_ready_out), .rd_valid_out(rd_valid_out),
    .rd_data_out(rd_data_out), .chip_select_n(chip_select_n), .output_enable_n(output_enable_n),
    .write_enable_n(write_enable_n), .byte_mask_out(byte_mask_out), .nand_read_strobe_n(nand_read_strobe_n),
    .nand_write_strobe_n(nand_write_strobe_n), .addr_out(addr_out), .data_out(data_out),
    .data_oe_out(data_oe_out), .data_in(data_in), .external_wait_in(external_wait_in),
    .addr_latch_count_in(addr_latch_count_in));

  mem_model mem_model_inst (
    .clk_in(clk_in), .cs_n_in(chip_select_n), .oe_n_in(output_enable_n), .we_n_in(write_enable_n),
    .mask_in(byte_mask_out), .nre_n_in(nand_read_strobe_n), .addr_in(addr_out), .wdata_in(data_out),
    .wdata_oe_in(data_oe_out), .rdata_out(data_in));

  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end

  task automatic finish_test();
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // per-access counters, sampled on the rising edge
  always @(posedge clk_in) begin
    cyc++;
    if (cyc > 40000) begin
      bad_count++;
      finish_test();
    end
    if (mon) begin
      if (chip_select_n[ca] === 1'b0) begin
        cnt[k_cs]++;
        seen = 1'b1;
      end else if (!seen) cnt[k_pre]++;
      else if (req_ready_out === 1'b0) cnt[k_idl]++;
      if (write_enable_n === 1'b0) wseen = 1'b1;
      if (chip_select_n[ca] === 1'b0 && !wseen) cnt[k_set]++;
      if (output_enable_n === 1'b0) mk = mk | byte_mask_out;
      cnt[k_oe] += int'(output_enable_n === 1'b0);
      cnt[k_we] += int'(write_enable_n === 1'b0);
      cnt[k_nre] += int'(nand_read_strobe_n === 1'b0);
      cnt[k_nwe] += int'(nand_write_strobe_n === 1'b0);
      cnt[k_dho] += int'(seen && chip_select_n[ca] !== 1'b0 && data_oe_out === 1'b1);
      if (rd_valid_out === 1'b1) rd = rd_data_out;
    end
  end

  task automatic wreg(input logic [2:0] a, input logic s, input logic [31:0] v);
    @(negedge clk_in);
    reg_wr_in = 1'b1;
    reg_area_in = a;
    reg_sel_tim_in = s;
    reg_wdata_in = v;
    @(negedge clk_in);
    reg_wr_in = 1'b0;
    repeat (2) @(negedge clk_in);
  endtask

  task automatic chkreg(input string n, input logic [2:0] a, input logic s, input logic [31:0] e);
    @(negedge clk_in);
    reg_area_in = a;
    reg_sel_tim_in = s;
    #1 `CHK(n, e, reg_rdata_out)
  endtask

  // settings only take effect when idle, so new words go in between accesses
  task automatic settim(input logic [2:0] a);
    tw = {write_idle_count, write_strobe_count, write_setup_count, write_access_count, read_idle_count, first_read_count, read_setup_count, read_access_count};
    wreg(a, 1'b1, tw);
  endtask

  task automatic acc(input logic [2:0] a, input logic w, input logic [7:0] ad, input logic [15:0] d,
                     input logic [1:0] ln, input int wl);
    int n;
    @(negedge clk_in);
    req_valid_in = 1'b1;
    req_write_in = w;
    req_area_in = a;
    req_addr_in = {17'h0, ad};
    req_wdata_in = d;
    req_lanes_in = ln;
    ca = a;
    while (req_ready_out !== 1'b1) @(negedge clk_in);
    @(posedge clk_in);
    @(negedge clk_in);
    req_valid_in = 1'b0;
    cnt = '{default: 0};
    mk = 2'h0;
    rd = 'x;
    seen = 1'b0;
    wseen = 1'b0;
    mon = 1'b1;
    n = 0;
    while (req_ready_out !== 1'b1 && n < 300) begin
      if (n == wl) external_wait_in = 1'b1;
      @(negedge clk_in);
      n++;
    end
    mon = 1'b0;
    external_wait_in = 1'b1;
    `CHK("access_done", 1, int'(n < 300))
  endtask

  task automatic do_wr(input logic [7:0] ad, input logic [15:0] d);
    acc(3'h4, 1'b1, ad, d, 2'h3, 0);
    exp_mem[ad] = d;
    `CHK("we_len", write_strobe_count + 1, cnt[k_we])
    `CHK("wr_setup", write_setup_count + 1, cnt[k_set])
    `CHK("wr_cs", write_access_count + 1, cnt[k_cs])
    `CHK("wr_idle", write_idle_count + 1, cnt[k_idl])
    `CHK("wr_hold", write_idle_count, cnt[k_dho])
  endtask

  task automatic do_rd(input logic [7:0] ad, input int oe_e);
    acc(3'h4, 1'b0, ad, 16'h0, 2'h3, 0);
    `CHK("rd_cs", read_access_count + 1, cnt[k_cs])
    `CHK("oe_len", oe_e, cnt[k_oe])
    `CHK("rd_idle", read_idle_count + 1, cnt[k_idl])
    `CHK("rd_data", exp_mem[ad], {16'h0, rd})
  endtask

  initial begin
    {arst_n_in, reg_wr_in, reg_sel_tim_in, req_valid_in, req_write_in, mon} = '0;
    {reg_area_in, req_area_in, ca, reg_wdata_in, req_addr_in, req_wdata_in, req_lanes_in} = '0;
    external_wait_in = 1'b1;
    void'($urandom(32'h97ef3bb1));
    addr_latch_count_in = 4'($urandom_range(7));
    repeat (16) @(negedge clk_in);
    arst_n_in = 1'b1;
    for (int a = 0; a < 8; a++) begin
      chkreg("mode_rst", 3'(a), 1'b0, (a == 4) ? 32'h1 : 32'h0);
      chkreg("tim_rst", 3'(a), 1'b1, 32'h055f_f00f);
    end
    wreg(3'h1, 1'b0, 32'h3d);
    chkreg("mode_rw", 3'h1, 1'b0, 32'h3d);
    wreg(3'h1, 1'b0, 32'h0);
    for (int i = 0; i < 6; i++) begin
      read_access_count = 4'($urandom_range(15, 3));
      read_setup_count = 4'($urandom_range(read_access_count - 1, 1));
      first_read_count = 4'(read_access_count - read_setup_count);
      read_idle_count = 4'($urandom_range(15));
      write_setup_count = 4'($urandom_range(6));
      write_strobe_count = 4'($urandom_range(6));
      write_access_count = write_setup_count + write_strobe_count + 4'($urandom_range(3, 2));
      write_idle_count = 4'($urandom_range(15));
      settim(3'h4);
      wreg(3'h4, 1'b0, i[0] ? 32'h2001 : 32'h1);
      do_wr(8'(2 * i + 2), 16'($urandom));
      do_rd(8'(2 * i + 2), i[0] ? first_read_count + 1 : read_access_count + 1 - read_setup_count);
    end
    {read_access_count, read_setup_count, first_read_count, read_idle_count, write_access_count, write_setup_count, write_strobe_count, write_idle_count} = {4'h5, 4'h1, 4'h0, 4'h1, 4'h5, 4'h1, 4'h2, 4'h1};
    settim(3'h4);
    wreg(3'h4, 1'b0, 32'h1);
    do_wr(8'h40, 16'h5aa5);
    wreg(3'h4, 1'b0, 32'h9);
    acc(3'h4, 1'b1, 8'h40, 16'h1234, 2'h3, 0);
    `CHK("we_off", 0, cnt[k_we])
    wreg(3'h4, 1'b0, 32'h5);
    acc(3'h4, 1'b0, 8'h40, 16'h0, 2'h1, 0);
    `CHK("rd_mask", 2'h2, mk)
    `CHK("rd_lane0", 8'ha5, rd[7:0])
    wreg(3'h4, 1'b0, 32'h1);
    do_rd(8'h40, read_access_count + 1 - read_setup_count);
    `CHK("no_mask", 2'h0, mk)
    external_wait_in = 1'b0;
    wreg(3'h4, 1'b0, 32'h41);
    acc(3'h4, 1'b0, 8'h40, 16'h0, 2'h3, 12);
    `CHK("wait_on", 1, int'(cnt[k_oe] > read_access_count + 1 - read_setup_count))
    external_wait_in = 1'b0;
    wreg(3'h4, 1'b0, 32'h1);
    acc(3'h4, 1'b0, 8'h40, 16'h0, 2'h3, 12);
    `CHK("wait_off", read_access_count + 1 - read_setup_count, cnt[k_oe])
    settim(3'h2);
    wreg(3'h2, 1'b0, 32'h10);
    `CHK("nand_cs", 1'b0, chip_select_n[2])
    acc(3'h2, 1'b0, 8'h20, 16'h0, 2'h1, 0);
    `CHK("nand_rd", read_access_count + 1 - read_setup_count, cnt[k_nre])
    acc(3'h2, 1'b1, 8'h20, 16'h00c3, 2'h1, 0);
    `CHK("nand_wr", write_strobe_count + 1, cnt[k_nwe])
    wreg(3'h2, 1'b0, 32'h0);
    `CHK("nand_off_cs", 1'b1, chip_select_n[2])
    settim(3'h5);
    wreg(3'h5, 1'b0, 32'h1101);
    acc(3'h5, 1'b1, 8'h10, 16'h0f0f, 2'h3, 0);
    `CHK("latch_cs_off", addr_latch_count_in + 1, cnt[k_pre])
    `CHK("mux_cs", write_access_count + 1, cnt[k_cs])
    {read_setup_count, first_read_count} = {4'h0, 4'h3};
    settim(3'h4);
    wreg(3'h4, 1'b0, 32'h21);
    acc(3'h4, 1'b0, 8'h40, 16'h0, 2'h3, 0);
    `CHK("page_first", first_read_count + read_access_count + 1, cnt[k_cs])
    `CHK("page_oe", first_read_count + read_access_count + 1, cnt[k_oe])
    `CHK("page_data", exp_mem[8'h40], {16'h0, rd})
    read_access_count = 4'hf;
    settim(3'h4);
    fork
      acc(3'h4, 1'b0, 8'h40, 16'h0, 2'h3, 0);
      begin
        repeat (3) @(negedge clk_in);
        wreg(3'h4, 1'b1, 32'h0114_1013);
        chkreg("tim_hold", 3'h4, 1'b1, tw);
      end
    join
    repeat (2) @(negedge clk_in);
    chkreg("tim_new", 3'h4, 1'b1, 32'h0114_1013);
    finish_test();
  end
endmodule
